// ---- logic/ectl_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ectl_top
  import ectl_pkg::*;
#(
  parameter int PKG_PINS = PINS_44
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire ectl_src_t src_i,
  // Current source control
  output logic current_drive_o,
  output logic source_ground_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge of a 16-bit register, limited to writable bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0]) v[7:0] = wd[7:0];
    if (sel[1]) v[15:8] = wd[15:8];
    return v & mask;
  endfunction

  // Edge or level qualification of one synchronised channel
  function automatic logic qualify(input logic mode, input logic pol,
                                   input logic cur, input logic prev);
    if (mode) return pol ? (cur & ~prev) : (~cur & prev);
    return cur == pol;
  endfunction

  // Channel one source; missing pins read low on small packages
  function automatic logic pick_one(input ectl_src_t s, input logic [3:0] c);
    case (c)
      4'hF: return s.cmp[2];
      4'hE: return s.cmp[1];
      4'hD: return s.cmp[0];
      4'hC: return s.clc[1];
      4'hB: return s.clc[0];
      4'hA: return s.ccp_flag[1];
      4'h9: return s.pin[8] & (PKG_PINS > PINS_28);
      4'h8: return s.pin[7] & (PKG_PINS > PINS_28);
      4'h7: return s.pin[6];
      4'h6: return s.pin[5];
      4'h5: return s.pin[4];
      4'h4: return s.pin[3] & (PKG_PINS > PINS_20);
      4'h3: return s.pin[1];
      4'h2: return s.pin[2];
      4'h1: return s.ccp_flag[0];
      default: return s.timer;
    endcase
  endfunction

  // Channel two source; unused codes give no source
  function automatic logic pick_two(input ectl_src_t s, input logic [3:0] c);
    case (c)
      4'hF: return s.cmp[2];
      4'hE: return s.cmp[1];
      4'hD: return s.cmp[0];
      4'hC: return 1'b0;
      4'hB: return s.clc[0];
      4'hA: return s.ccp_flag[1];
      4'h9: return 1'b0;
      4'h8: return s.pin[13];
      4'h7: return s.pin[12];
      4'h6: return s.pin[11] & (PKG_PINS > PINS_20);
      4'h5: return s.pin[10];
      4'h4: return s.pin[9] & (PKG_PINS > PINS_20);
      4'h3: return s.pin[1];
      4'h2: return s.pin[2];
      4'h1: return s.ccp_flag[0];
      default: return s.timer;
    endcase
  endfunction

  // Discharge source; 000 and the reserved code give none
  function automatic logic pick_dis(input ectl_src_t s, input logic [2:0] c);
    case (c)
      3'h7: return s.clc[1];
      3'h6: return s.clc[0];
      3'h4: return s.adc_eoc;
      3'h3: return s.aux[2];
      3'h2: return s.aux[1];
      3'h1: return s.aux[0];
      default: return 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] chan_q, chan_d, dis_q, dis_d, unit_q, unit_d;
  logic flag1_q, flag1_d, flag2_q, flag2_d;
  logic [2:0] sy1_q, sy1_d, sy2_q, sy2_d;
  logic [1:0] prev_q, prev_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic drive_q, drive_d, gnd_q, gnd_d;
  logic take, wr, wr_chan, go, ev1, ev2, det_rst, dis_sig;
  logic [15:0] rd;

  // ---------------------------------------------------------------
  // Bus decode and edge qualification
  // ---------------------------------------------------------------
  always_comb begin
    take = wb_cyc_i & wb_stb_i & ~ack_q;
    // Writes land on the edge where the master sees ack
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    wr_chan = wr & (wb_adr_i == CHAN_ADDR);
    go = unit_q[U_EN] & unit_q[U_PASS];
    ev1 = go & qualify(chan_q[F1_MODE], chan_q[F1_POL], sy2_q[0], prev_q[0]);
    ev2 = go & qualify(chan_q[F2_MODE], chan_q[F2_POL], sy2_q[1], prev_q[1])
        & (~unit_q[U_ORDER] | flag1_q);
    // Selector 000 falls back to the ground control bit
    dis_sig = (dis_q[DIS_SEL +: DIS_W] == DIS_NONE) ? unit_q[U_GND] : sy2_q[2];
    det_rst = dis_q[RST_EN] & dis_sig;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Sources are muxed raw, then pass two flops before any detector looks
  always_comb begin
    sy1_d = {pick_dis(src_i, dis_q[DIS_SEL +: DIS_W]),
             pick_two(src_i, chan_q[F2_SEL +: SEL_W]),
             pick_one(src_i, chan_q[F1_SEL +: SEL_W])};
    sy2_d = sy1_q;
    prev_d = sy2_q[1:0];
  end

  // Registers and flags; detector reset beats a set, a set beats a write
  always_comb begin
    chan_d = chan_q;
    dis_d = dis_q;
    unit_d = unit_q;
    flag1_d = flag1_q;
    flag2_d = flag2_q;
    if (wr_chan) chan_d = merge(chan_q, wb_dat_i, wb_sel_i, CHAN_WMASK);
    if (wr & (wb_adr_i == DISCH_ADDR))
      dis_d = merge(dis_q, wb_dat_i, wb_sel_i, DISCH_WMASK);
    if (wr & (wb_adr_i == UNIT_ADDR)) unit_d = merge(unit_q, wb_dat_i, wb_sel_i, UNIT_WMASK);
    if (wr_chan & wb_sel_i[1]) begin
      flag1_d = wb_dat_i[F1_STAT];
      flag2_d = wb_dat_i[F2_STAT];
    end
    if (ev1) flag1_d = 1'b1;
    if (ev2) flag2_d = 1'b1;
    if (det_rst) begin
      flag1_d = 1'b0;
      flag2_d = 1'b0;
    end
  end

  // Read data, ack and analog controls
  always_comb begin
    case (wb_adr_i)
      CHAN_ADDR: rd = chan_q;
      DISCH_ADDR: rd = dis_q;
      UNIT_ADDR: rd = unit_q;
      default: rd = REG_RESET;
    endcase
    rd[F1_STAT] = rd[F1_STAT] | ((wb_adr_i == CHAN_ADDR) & flag1_q);
    rd[F2_STAT] = rd[F2_STAT] | ((wb_adr_i == CHAN_ADDR) & flag2_q);
    ack_d = take;
    dat_d = take ? {16'h0000, rd} : 32'h0000_0000;
    // Grounding wins over the flags: a grounded source never drives
    drive_d = unit_q[U_EN] & flag1_q & ~flag2_q & ~unit_q[U_GND];
    gnd_d = unit_q[U_GND];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= REG_RESET;
      dis_q <= REG_RESET;
      unit_q <= REG_RESET;
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
      prev_q <= 2'h0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      drive_q <= 1'b0;
      gnd_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      dis_q <= dis_d;
      unit_q <= unit_d;
      flag1_q <= flag1_d;
      flag2_q <= flag2_d;
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
      prev_q <= prev_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      drive_q <= drive_d;
      gnd_q <= gnd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign current_drive_o = drive_q;
  assign source_ground_o = gnd_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Edge shapes used by the flag-set checks
  sequence s_rise_one;
    chan_q[F1_MODE] && chan_q[F1_POL] && sy2_q[0] && !prev_q[0] && go;
  endsequence
  sequence s_fall_two;
    chan_q[F2_MODE] && !chan_q[F2_POL] && !sy2_q[1] && prev_q[1] && go
      && (!unit_q[U_ORDER] || flag1_q);
  endsequence

  a_rise_sets_one: assert property (s_rise_one ##0 !det_rst |=> flag1_q)
    else $error("rising edge did not set first flag");
  a_fall_sets_two: assert property (s_fall_two ##0 !det_rst |=> flag2_q)
    else $error("falling edge did not set second flag");
  a_level_one: assert property (!chan_q[F1_MODE] && go
      && sy2_q[0] == chan_q[F1_POL] && !det_rst |=> flag1_q)
    else $error("level mode did not qualify first channel");
  // Software writes of the flags are left out: only hardware sets are watched
  a_blocked_pass: assert property ((!unit_q[U_PASS] || !unit_q[U_EN])
      && !(wr_chan && wb_sel_i[1]) |=> !$rose(flag1_q) && !$rose(flag2_q))
    else $error("edge passed while blocked");
  a_order_hold: assert property (unit_q[U_ORDER] && !flag1_q
      && !(wr_chan && wb_sel_i[1]) |=> !$rose(flag2_q))
    else $error("second edge taken before first");
  a_det_clear: assert property (det_rst |=> !flag1_q && !flag2_q)
    else $error("detector reset did not clear flags");
  a_no_det_reset: assert property (!dis_q[RST_EN] && flag1_q
      && !(wr_chan && wb_sel_i[1]) |=> flag1_q)
    else $error("detector reset without enable");
  // Ground fallback is not synchronised, so it clears on the very next edge
  a_ground_reset: assert property (dis_q[RST_EN] && unit_q[U_GND]
      && dis_q[DIS_SEL +: DIS_W] == DIS_NONE |=> !flag1_q && !flag2_q)
    else $error("ground control did not clear flags");
  a_upper_zero: assert property (take && !wb_we_i && wb_adr_i == DISCH_ADDR
      |=> wb_dat_o[15:5] == 11'h000 && wb_dat_o[3] == 1'b0)
    else $error("discharge register upper bits not zero");
  a_drive_cause: assert property (current_drive_o
      |-> $past(flag1_q && !flag2_q && unit_q[U_EN] && !unit_q[U_GND]))
    else $error("current drive without cause");
  a_ground_follow: assert property ($rose(unit_q[U_GND]) |=> source_ground_o ##1 !current_drive_o)
    else $error("ground control not applied");
  // An edge seen now must have entered the first flop two edges earlier
  a_sync_path: assert property (ev1 && chan_q[F1_MODE]
      |-> $past(sy1_q[0]) != $past(sy1_q[0], 2))
    else $error("synchroniser path broken");
  // Small packages: a missing pin must never reach a synchroniser
  a_absent_one: assert property (
    (PKG_PINS <= PINS_28 && chan_q[F1_SEL +: SEL_W] inside {4'h8, 4'h9})
      || (PKG_PINS <= PINS_20 && chan_q[F1_SEL +: SEL_W] == 4'h4) |-> !sy1_d[0])
    else $error("missing pin reached first channel");
  a_absent_two: assert property (
    PKG_PINS <= PINS_20 && chan_q[F2_SEL +: SEL_W] inside {4'h4, 4'h6} |-> !sy1_d[1])
    else $error("missing pin reached second channel");
  a_ack_once: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");

endmodule // ectl_top
`default_nettype wire

// ---- logic/ectl_pkg.sv ----
`default_nettype none
package ectl_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] CHAN_ADDR = 4'h0;
  localparam logic [3:0] DISCH_ADDR = 4'h4;
  localparam logic [3:0] UNIT_ADDR = 4'h8;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Writable bits per register; all others read as zero except the channel flag bits 9:8
  localparam logic [15:0] CHAN_WMASK = 16'hFCFC;
  localparam logic [15:0] DISCH_WMASK = 16'h0017;
  localparam logic [15:0] UNIT_WMASK = 16'h8E00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int F1_MODE = 15;
  localparam int F1_POL = 14;
  localparam int F1_SEL = 10;
  localparam int F2_STAT = 9;
  localparam int F1_STAT = 8;
  localparam int F2_MODE = 7;
  localparam int F2_POL = 6;
  localparam int F2_SEL = 2;
  localparam int SEL_W = 4;
  localparam int RST_EN = 4;
  localparam int DIS_SEL = 0;
  localparam int DIS_W = 3;
  localparam int U_EN = 15;
  localparam int U_PASS = 11;
  localparam int U_ORDER = 10;
  localparam int U_GND = 9;
  localparam logic [2:0] DIS_NONE = 3'h0;
  // Package pin counts
  localparam int PINS_20 = 20;
  localparam int PINS_28 = 28;
  localparam int PINS_44 = 44;
  // ---------------------------------------------------------------
  // Event sources entering the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cmp;
    logic [1:0] clc;
    logic [1:0] ccp_flag;
    logic timer;
    logic [13:1] pin;
    logic adc_eoc;
    logic [2:0] aux;
  } ectl_src_t;
endpackage
`default_nettype wire

// ---- dv/ectl_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Event sources and edge pins outside the block; levels move only just after a clock edge
module ectl_src_model
  import ectl_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Source levels toward the block
  output var ectl_src_t src_o
);
  logic [$bits(ectl_src_t)-1:0] lvl_q = '0;
  // Packed view of all source levels
  assign src_o = ectl_src_t'(lvl_q);
  // Move one source; reserved selector codes are never used by the bench
  task automatic drive(input int idx, input logic val);
    @(posedge clk_i);
    lvl_q[idx] <= val;
  endtask
endmodule // ectl_src_model
`default_nettype wire

// ---- dv/ectl_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ectl_top_tb
  import ectl_pkg::*;
;
  // -------------------------------------------------------------
  // Harness
  // -------------------------------------------------------------
  localparam int LIMIT = 20000;
  localparam int MAP1[16] = '{17, 18, 5, 4, 6, 7, 8, 9, 10, 11, 19, 20, 21, 22, 23, 24};
  localparam int MAP2[16] = '{17, 18, 5, 4, 12, 13, 14, 15, 16, -1, 19, 20, -1, 22, 23, 24};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic drv;
  logic gnd;
  ectl_src_t src;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] cfg;
  logic [15:0] expv;
  int b;
  logic gone;
  logic [1:0] sm;
  logic [1:0] sfl;
  ectl_top i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .src_i(src), .current_drive_o(drv), .source_ground_o(gnd));
  // Smallest package: pins 3, 7, 8, 9 and 11 are missing
  ectl_top #(.PKG_PINS(PINS_20)) i_dut_small (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(), .wb_ack_o(), .src_i(src), .current_drive_o(), .source_ground_o());
  ectl_src_model i_src (.clk_i(clk), .src_o(src));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    sel <= 4'h3;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    check(nm, q, {16'h0000, exp});
  endtask
  // Long enough for the two-flop synchroniser, the flag and the drive stage
  task automatic w6();
    repeat (6) @(posedge clk);
  endtask
  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(CHAN_ADDR, 16'h0000, "chan reset");
    rc(UNIT_ADDR, 16'h0000, "unit reset");
    wr(4'hC, 16'hFFFF);
    rc(4'hC, 16'h0000, "unmapped");
    wr(DISCH_ADDR, 16'hFFFF);
    rc(DISCH_ADDR, 16'h0017, "disch mask");
    wr(DISCH_ADDR, 16'h0000);
    wr(UNIT_ADDR, 16'h8800);
    // Every source code of both channels, rising edge; the idle channel watches the timer
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 0; code < 16; code++) begin
        b = (ch == 1) ? MAP2[code] : MAP1[code];
        if (b < 0) continue;
        cfg = (ch == 1) ? (16'hC0C0 | 16'(code << 2)) : (16'hC0C0 | 16'(code << 10));
        expv = cfg | ((ch == 1) ? 16'h0200 : 16'h0100) | ((code == 0) ? 16'h0300 : 16'h0000);
        wr(CHAN_ADDR, cfg);
        i_src.drive(b, 1'b1);
        w6();
        rc(CHAN_ADDR, expv, "source flag");
        @(negedge clk);
        check("drive", {31'h0, drv}, {31'h0, expv[8] & ~expv[9]});
        gone = (ch == 1) ? (code == 4 || code == 6) : (code == 4 || code == 8 || code == 9);
        sm = gone ? 2'b00 : expv[9:8];
        sfl = {i_dut_small.flag2_q, i_dut_small.flag1_q};
        check("small pkg", {30'h0, sfl}, {30'h0, sm});
        i_src.drive(b, 1'b0);
      end
    end
    // Falling edge on pin one: the rise is ignored, the fall is recorded
    wr(CHAN_ADDR, 16'h8CC0);
    i_src.drive(4, 1'b1);
    w6();
    rc(CHAN_ADDR, 16'h8CC0, "rise ignored");
    i_src.drive(4, 1'b0);
    w6();
    rc(CHAN_ADDR, 16'h8DC0, "fall seen");
    // Level mode, low polarity, timer held low
    wr(CHAN_ADDR, 16'h0000);
    w6();
    rc(CHAN_ADDR, 16'h0300, "low level");
    // Edges blocked with pass off, then with the unit off
    for (int k = 0; k < 2; k++) begin
      wr(UNIT_ADDR, (k == 0) ? 16'h8000 : 16'h0800);
      wr(CHAN_ADDR, 16'hC0C0);
      i_src.drive(17, 1'b1);
      w6();
      rc(CHAN_ADDR, 16'hC0C0, "blocked");
      i_src.drive(17, 1'b0);
    end
    // Ordering: second event waits for the first
    wr(UNIT_ADDR, 16'h8C00);
    wr(CHAN_ADDR, 16'hCCC0);
    i_src.drive(17, 1'b1);
    w6();
    rc(CHAN_ADDR, 16'hCCC0, "order hold");
    i_src.drive(4, 1'b1);
    w6();
    rc(CHAN_ADDR, 16'hCDC0, "order first");
    i_src.drive(17, 1'b0);
    w6();
    i_src.drive(17, 1'b1);
    w6();
    rc(CHAN_ADDR, 16'hCFC0, "order second");
    i_src.drive(4, 1'b0);
    i_src.drive(17, 1'b0);
    // Software writes of the flags steer the current source
    wr(UNIT_ADDR, 16'h8800);
    wr(CHAN_ADDR, 16'hC1C0);
    w6();
    check("sw drive on", {31'h0, drv}, 32'h00000001);
    wr(CHAN_ADDR, 16'hC3C0);
    w6();
    check("sw drive off", {31'h0, drv}, 32'h00000000);
    wr(UNIT_ADDR, 16'h8A00);
    w6();
    check("ground on", {31'h0, gnd}, 32'h00000001);
    wr(UNIT_ADDR, 16'h8800);
    w6();
    check("ground off", {31'h0, gnd}, 32'h00000000);
    // Discharge from conversion end: ignored until reset enable is set
    wr(DISCH_ADDR, 16'h0004);
    i_src.drive(3, 1'b1);
    wr(CHAN_ADDR, 16'hC1C0);
    w6();
    rc(CHAN_ADDR, 16'hC1C0, "no detector reset");
    wr(DISCH_ADDR, 16'h0014);
    w6();
    rc(CHAN_ADDR, 16'hC0C0, "detector reset");
    i_src.drive(3, 1'b0);
    // Every other discharge source clears the first flag once reset enable is set
    for (int code = 1; code < 8; code++) begin
      if (code == 4 || code == 5) continue;
      b = (code > 5) ? code + 14 : code - 1;
      wr(DISCH_ADDR, 16'h0010 | 16'(code));
      wr(CHAN_ADDR, 16'hC1C0);
      w6();
      rc(CHAN_ADDR, 16'hC1C0, "discharge idle");
      i_src.drive(b, 1'b1);
      w6();
      rc(CHAN_ADDR, 16'hC0C0, "discharge source");
      i_src.drive(b, 1'b0);
    end
    // Selector 000 falls back to the ground control bit
    wr(DISCH_ADDR, 16'h0010);
    wr(CHAN_ADDR, 16'hC1C0);
    rc(CHAN_ADDR, 16'hC1C0, "ground idle");
    wr(UNIT_ADDR, 16'h8A00);
    rc(CHAN_ADDR, 16'hC0C0, "ground reset");
    // Mid-run reset returns every register and output to zero
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(CHAN_ADDR, 16'h0000, "chan rerun");
    rc(DISCH_ADDR, 16'h0000, "disch rerun");
    rc(UNIT_ADDR, 16'h0000, "unit rerun");
    check("ground rerun", {31'h0, gnd}, 32'h00000000);
    finish_test();
  end
endmodule // ectl_top_tb
`default_nettype wire
